/* File: common/srss_pkg.sv */
package srss_pkg;
    // Clock and watchdog timing
    localparam int CLK_HZ = 50_000_000; // System clock rate
    localparam int WDT_STEP_MS = 10; // Limit increment
    localparam int WDT_MIN_MS = 10; // Least limit
    localparam int WDT_MAX_MS = 2000; // Largest limit
    localparam int WDT_INIT_MS = 200; // Limit after init
    // Cycles per watchdog step, one step is one tick
    localparam int WDT_TICK_CYC = CLK_HZ / 1000 * WDT_STEP_MS;
    localparam int WD_LIM_W = 8; // Limit held in steps
    localparam logic [7:0] WD_LIM_MIN = 8'(WDT_MIN_MS / WDT_STEP_MS);
    localparam logic [7:0] WD_LIM_MAX = 8'(WDT_MAX_MS / WDT_STEP_MS);
    localparam logic [7:0] WD_LIM_INIT = 8'(WDT_INIT_MS / WDT_STEP_MS);
    // Input points, lowest to highest address
    localparam int INPUT_POINTS = 'h90; // Input point range
    localparam int PT_IDX_W = 8; // Point index width
    // Bus map, byte addresses
    localparam int ADDR_W = 8; // Decoded address bits
    localparam logic [7:0] ADDR_CTRL = 8'h00; // Control
    localparam logic [7:0] ADDR_PSEL = 8'h04; // Remote point select
    localparam logic [7:0] ADDR_WDSET = 8'h08; // Watchdog limit
    localparam logic [7:0] ADDR_STAT = 8'h0c; // Status, W1C flags
    localparam logic [7:0] ADDR_ECODE = 8'h10; // Error code word
    // Control fields
    localparam int CTRL_W = 3; // Control width
    localparam int CTRL_TOOL_STOP = 0; // Tool requests stop
    localparam int CTRL_PT_EN = 1; // Remote point in use
    localparam int CTRL_OPERR_STOP = 2; // Operation errors stop
    localparam logic [2:0] CTRL_RST = 3'h0; // Continue, no point
    // Status fields
    localparam int SB_RUN = 0; // Engine runs
    localparam int SB_DRAIN = 1; // Finishing scan
    localparam int SB_FAULT = 2; // Stopped by error
    localparam int SB_WDT = 3; // Watchdog error flag
    localparam int SB_DIAG = 4; // Diagnostic error flag
    localparam int SB_SDIAG = 5; // Self-diagnostic error flag
    // Error codes
    localparam int ECODE_W = 16; // Error code width
    localparam logic [15:0] ERR_BCD = 16'h0032; // BCD range error
    localparam logic [15:0] ERR_WDT = 16'h0001; // Watchdog error
    localparam logic [15:0] ERR_INIT = 16'h0002; // Start-up check
    // Run indicator blink half period in ticks
    localparam int BLINK_W = 6; // Blink counter width
    localparam logic [5:0] BLINK_TICKS = 6'h32; // 500 ms
    // Supervisor states
    typedef enum logic [2:0] {
        ST_INIT, ST_STOP, ST_RUN, ST_DRAIN, ST_FAULT
    } srss_state_t;
endpackage

/* File: common/srss_eng_if.sv */
interface srss_eng_if;
    import srss_pkg::*;
    logic ce; // Clock enable
    logic enable; // Watchdog counts
    logic clear; // Restart scan count
    logic [WD_LIM_W-1:0] limit; // Limit in steps
    logic expire; // Scan over limit
    logic tick; // One step elapsed
    logic [INPUT_POINTS-1:0] points; // Input points
    logic [PT_IDX_W-1:0] index; // Selected point
    logic pointOn; // Selected point level
    modport core (output ce, enable, clear, limit, points, index,
        input expire, tick, pointOn);
    modport wdog (input ce, enable, clear, limit,
        output expire, tick);
    modport psel (input ce, points, index, output pointOn);
endinterface

/* File: design/srss_point_sel.sv */
module srss_point_sel
    import srss_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic rst_n, // Async reset, low
    srss_eng_if.psel ifc // Point select side
);
    typedef struct packed {
        logic pointOn; // Sampled point
    } srss_psel_t;
    srss_psel_t q; // State
    srss_psel_t n; // Next state
    logic [INPUT_POINTS-1:0] hitV; // One-hot match
    logic selBit; // Helper for the check
    // One comparator per point
    genvar gi;
    generate
        for (gi = 0; gi < INPUT_POINTS; gi++)
        begin : g_pt
            assign hitV[gi] = ifc.points[gi] &&
                (ifc.index == PT_IDX_W'(gi)); // [RL6]
        end
    endgenerate
    assign selBit = |hitV; // Out of range index reads off
    // Next value
    always_comb
    begin
        n = q;
        if (ifc.ce)
            n.pointOn = selBit;
    end
    // Register
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= n;
    end
    assign ifc.pointOn = q.pointOn;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_point_sel;
        ifc.ce |=> q.pointOn == $past(selBit);
    endproperty
    a_point_sel: assert property (p_point_sel) // [RL6]
        else $error("selected point level not followed");
endmodule

/* File: design/srss_scan_supervision_timer.sv */
module srss_scan_supervision_timer
    import srss_pkg::*;
#(
    parameter int TICK_CYCLES = WDT_TICK_CYC // Cycles per step
)
(
    input wire logic sys_clk, // System clock
    input wire logic rst_n, // Async reset, low
    srss_eng_if.wdog ifc // Watchdog side
);
    localparam int TW = $clog2(TICK_CYCLES + 1); // Prescaler width
    typedef struct packed {
        logic [TW-1:0] pre; // Prescaler
        logic [WD_LIM_W-1:0] steps; // Steps this scan
        logic expire; // Over limit
        logic tick; // Step pulse
    } srss_wd_t;
    srss_wd_t q; // State
    srss_wd_t n; // Next state
    // Prescaler restarts with the scan, so a step is exact
    always_comb
    begin
        n = q;
        if (ifc.ce)
        begin
            n.tick = 1'b0;
            if (ifc.clear)
            begin
                n.pre = '0; // [RL11]
                n.steps = '0; // [RL11]
                n.expire = 1'b0;
            end
            else if (q.pre == TW'(TICK_CYCLES - 1))
            begin
                n.pre = '0;
                n.tick = 1'b1; // [RL20]
                if (ifc.enable && !q.expire)
                begin
                    n.steps = q.steps + 8'h01; // [RL20]
                    n.expire = (q.steps + 8'h01) >= ifc.limit; // [RL20]
                end
            end
            else
                n.pre = q.pre + TW'(1);
            // Idle engine holds no count
            if (!ifc.enable)
            begin
                n.steps = '0;
                n.expire = 1'b0;
            end
        end
    end
    // Register
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= n;
    end
    assign ifc.expire = q.expire;
    assign ifc.tick = q.tick;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_wd_clear;
        ifc.ce && ifc.clear |=> q.steps == '0 && !q.expire;
    endproperty
    a_wd_clear: assert property (p_wd_clear) // [RL11]
        else $error("scan count not restarted");
    property p_wd_limit;
        $rose(q.expire) |-> q.tick && q.steps >= ifc.limit;
    endproperty
    a_wd_limit: assert property (p_wd_limit) // [RL20]
        else $error("watchdog expired off a step or early");
endmodule

/* File: design/srss_supervisor.sv */
// Notes on behaviour
// RL1 - Run permit on runs, off stops
// RL2 - Remote requests act only under run permit
// RL3 - Remote stop finishes scan to END first
// RL4 - Remote run restarts program at step zero
// RL5 - Remote point off means run, on stop
// RL6 - Remote point selectable over whole input range
// RL7 - Any single stop source forces stop
// RL8 - Run resumes only when all sources withdraw
// RL9 - Run scans repeatedly; stop forces outputs off
// RL10 - Watchdog limit configurable, stepped, default 200ms
// RL11 - Watchdog restarts between END and step zero
// RL12 - Watchdog error: outputs off, indicator blinks
// RL13 - Watchdog error sets self-diag flag, code
// RL14 - Diagnose at start-up, instructions and END
// RL15 - Stop-class error halts program at once
// RL16 - Continue-class error skips to next step
// RL17 - Operation error sets diag flag, code
// RL18 - Setting picks stop or continue on errors
// RL19 - BCD range error continues, code fifty, lit; code stops on it when CTRL_OPERR_STOP is set
// RL20 - Watchdog counts fixed ticks against limit
module srss_supervisor
    import srss_pkg::*;
#(
    parameter int TICK_CYCLES = WDT_TICK_CYC // Cycles per step
)
(
    input wire logic sys_clk, // System clock
    input wire logic rst_n, // Async reset, low
    input wire logic ce, // Clock enable
    input wire logic hsel, // AHB select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size, word only
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response
    input wire logic runPermitInput, // Run permit
    input wire logic [INPUT_POINTS-1:0] inPoints, // Input points
    input wire logic hwDiagOk, // Start-up check good
    input wire logic scanEnd, // END processing done
    input wire logic instrErr, // Instruction fault
    input wire logic instrErrStop, // Fault is stop class
    input wire logic [ECODE_W-1:0] instrErrCode, // Fault code
    input wire logic opErr, // Operation error
    input wire logic [ECODE_W-1:0] opErrCode, // Its code
    input wire logic bcdErr, // BCD range error
    output logic engRun, // Engine executes
    output logic engRestart, // Start at step zero
    output logic engSkip, // Skip faulty area
    output logic outputsOff, // Force all outputs off
    output logic runLed, // Run indicator
    output logic diagErrorFlag, // Diagnostic error
    output logic selfDiagErrorFlag, // Self-diag error
    output logic [ECODE_W-1:0] errorCodeWord // Last code
);
    typedef struct packed {
        srss_state_t state; // Supervisor state
        logic [CTRL_W-1:0] ctrl; // Control bits
        logic [PT_IDX_W-1:0] psel; // Remote point index
        logic [WD_LIM_W-1:0] wdLimit; // Limit in steps
        logic wdtFlag; // Watchdog error seen
        logic diagFlag; // Diagnostic error seen
        logic sdiagFlag; // Self-diag error seen
        logic wdtCause; // Fault came from watchdog
        logic [ECODE_W-1:0] ecode; // Error code word
        logic [BLINK_W-1:0] blinkCnt; // Blink tick count
        logic blink; // Blink phase
        logic restart; // Step zero pulse
        logic skip; // Skip pulse
        logic run; // Engine runs
        logic outOff; // Outputs forced off
        logic led; // Indicator level
        logic wrPend; // Write data phase due
        logic [ADDR_W-1:0] wrAddr; // Write target
        logic [31:0] rdata; // Read data
        logic readyOut; // Slave ready
    } srss_core_t;
    localparam srss_core_t CORE_RST = '{
        state: ST_INIT,
        ctrl: CTRL_RST,
        wdLimit: WD_LIM_INIT, // [RL10]
        outOff: 1'b1,
        readyOut: 1'b1,
        default: '0
    };
    srss_core_t q; // State
    srss_core_t n; // Next state
    srss_eng_if ifc(); // Link to timer and point select
    logic stopReq; // Some source asks stop
    logic runLike; // Executing with permit
    logic errStop; // Stop-class error now
    logic opAny; // Operation error of any kind
    logic addrPh; // Valid address phase
    // Watchdog timer
    srss_scan_supervision_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_wdog (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ifc(ifc.wdog)
    );
    // Remote run point select
    srss_point_sel u_psel (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .ifc(ifc.psel)
    );
    // Step count runs only while a scan is in progress
    assign ifc.ce = ce;
    assign ifc.enable = (q.state == ST_RUN) || (q.state == ST_DRAIN);
    assign ifc.clear = scanEnd || q.restart; // [RL11]
    assign ifc.limit = q.wdLimit; // [RL10]
    assign ifc.points = inPoints;
    assign ifc.index = q.psel; // [RL6]
    // Point on asks stop; tool bit asks stop; either wins
    assign stopReq = (q.ctrl[CTRL_PT_EN] && ifc.pointOn) ||
        q.ctrl[CTRL_TOOL_STOP]; // [RL5] [RL7]
    assign runLike = ifc.enable && runPermitInput; // [RL14]
    assign opAny = opErr || bcdErr;
    // Fault priority: watchdog, instruction, operation
    assign errStop = runLike && (ifc.expire ||
        (instrErr && instrErrStop) ||
        (!instrErr && opAny && q.ctrl[CTRL_OPERR_STOP]));
    assign addrPh = hsel && htrans[1] && hready;
    // Bus, errors, state and outputs in one pass
    always_comb
    begin
        logic [31:0] rd;
        rd = '0;
        n = q;
        if (ce)
        begin
            n.restart = 1'b0;
            n.skip = 1'b0;
            n.wrPend = 1'b0;
            // Write data phase; clears land before sets
            if (q.wrPend)
            begin
                case (q.wrAddr)
                    ADDR_CTRL: n.ctrl = hwdata[CTRL_W-1:0]; // [RL18]
                    ADDR_PSEL: n.psel = hwdata[PT_IDX_W-1:0]; // [RL6]
                    ADDR_WDSET:
                    begin
                        // Out of range limits are clamped
                        if (hwdata[WD_LIM_W-1:0] < WD_LIM_MIN)
                            n.wdLimit = WD_LIM_MIN; // [RL10]
                        else if (hwdata[WD_LIM_W-1:0] > WD_LIM_MAX)
                            n.wdLimit = WD_LIM_MAX; // [RL10]
                        else
                            n.wdLimit = hwdata[WD_LIM_W-1:0]; // [RL10]
                    end
                    ADDR_STAT:
                    begin
                        if (hwdata[SB_WDT])
                            n.wdtFlag = 1'b0;
                        if (hwdata[SB_DIAG])
                            n.diagFlag = 1'b0;
                        if (hwdata[SB_SDIAG])
                            n.sdiagFlag = 1'b0;
                    end
                    default: ; // Unmapped or read-only
                endcase
            end
            // Address phase
            if (addrPh)
            begin
                n.wrPend = hwrite;
                n.wrAddr = haddr[ADDR_W-1:0];
            end
            // Error detection while executing
            if (runLike)
            begin
                if (ifc.expire)
                begin
                    n.wdtFlag = 1'b1; // [RL12]
                    n.sdiagFlag = 1'b1; // [RL13]
                    n.ecode = ERR_WDT; // [RL13]
                    n.wdtCause = 1'b1; // [RL12]
                end
                else if (instrErr)
                begin
                    n.sdiagFlag = 1'b1; // [RL14]
                    n.ecode = instrErrCode; // [RL14]
                    n.skip = !instrErrStop; // [RL16]
                end
                else if (opAny)
                begin
                    n.diagFlag = 1'b1; // [RL17] [RL19]
                    n.ecode = bcdErr ? ERR_BCD : opErrCode; // [RL17] [RL19]
                    n.skip = !q.ctrl[CTRL_OPERR_STOP]; // [RL18] [RL19]
                end
            end
            // Run and stop sequencing
            if (q.state == ST_INIT)
            begin
                // Start-up check decides first state
                if (hwDiagOk)
                    n.state = ST_STOP; // [RL14]
                else
                begin
                    n.state = ST_FAULT; // [RL14]
                    n.sdiagFlag = 1'b1; // [RL14]
                    n.ecode = ERR_INIT; // [RL14]
                end
            end
            else if (!runPermitInput)
            begin
                // Permit off stops at once, also leaves a fault
                n.state = ST_STOP; // [RL1] [RL2]
                n.wdtCause = 1'b0;
            end
            else if (errStop)
                n.state = ST_FAULT; // [RL12] [RL15] [RL18]
            else
            begin
                case (q.state)
                    ST_STOP:
                    begin
                        // Every stop source must have let go
                        if (!stopReq)
                        begin
                            n.state = ST_RUN; // [RL1] [RL8]
                            n.restart = 1'b1; // [RL4]
                        end
                    end
                    ST_RUN:
                    begin
                        if (stopReq)
                            n.state = ST_DRAIN; // [RL2] [RL7]
                    end
                    ST_DRAIN:
                    begin
                        // Scan is finished before stopping
                        if (scanEnd)
                            n.state = ST_STOP; // [RL3]
                    end
                    ST_FAULT: ; // Held until permit drops
                    default: n.state = ST_STOP;
                endcase
            end
            // Blink runs only for a watchdog fault
            if (n.state == ST_FAULT && n.wdtCause)
            begin
                if (ifc.tick)
                begin
                    if (q.blinkCnt == BLINK_TICKS - 6'h01)
                    begin
                        n.blinkCnt = '0;
                        n.blink = !q.blink; // [RL12]
                    end
                    else
                        n.blinkCnt = q.blinkCnt + 6'h01;
                end
            end
            else
            begin
                n.blinkCnt = '0;
                n.blink = 1'b1;
            end
            // Outputs follow the next state
            n.run = (n.state == ST_RUN) || (n.state == ST_DRAIN); // [RL9]
            n.outOff = !n.run; // [RL9] [RL12]
            if (n.run)
                n.led = 1'b1; // [RL19]
            else if (n.state == ST_FAULT && n.wdtCause)
                n.led = n.blink; // [RL12]
            else
                n.led = 1'b0;
            // Read mux sees this cycle's write
            case (haddr[ADDR_W-1:0])
                ADDR_CTRL: rd[CTRL_W-1:0] = n.ctrl;
                ADDR_PSEL: rd[PT_IDX_W-1:0] = n.psel;
                ADDR_WDSET: rd[WD_LIM_W-1:0] = n.wdLimit;
                ADDR_STAT:
                begin
                    rd[SB_RUN] = q.state == ST_RUN;
                    rd[SB_DRAIN] = q.state == ST_DRAIN;
                    rd[SB_FAULT] = q.state == ST_FAULT;
                    rd[SB_WDT] = n.wdtFlag;
                    rd[SB_DIAG] = n.diagFlag;
                    rd[SB_SDIAG] = n.sdiagFlag;
                end
                ADDR_ECODE: rd[ECODE_W-1:0] = n.ecode;
                default: rd = '0; // Unmapped reads zero
            endcase
            n.rdata = (addrPh && !hwrite) ? rd : '0;
            n.readyOut = 1'b1; // Zero wait states
        end
    end
    // Register
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= CORE_RST;
        else
            q <= n;
    end
    // Outputs straight from the state register, hresp tied low
    assign hrdata = q.rdata;
    assign hreadyout = q.readyOut;
    assign hresp = 1'b0;
    assign engRun = q.run;
    assign engRestart = q.restart;
    assign engSkip = q.skip;
    assign outputsOff = q.outOff;
    assign runLed = q.led;
    assign diagErrorFlag = q.diagFlag;
    assign selfDiagErrorFlag = q.sdiagFlag;
    assign errorCodeWord = q.ecode;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_restart;
        engRestart && engRun ##1 !engRestart;
    endsequence
    sequence s_wd_fault;
        outputsOff && !engRun && q.wdtFlag && selfDiagErrorFlag;
    endsequence
    property p_permit_off;
        ce && !runPermitInput && q.state != ST_INIT
            |=> !engRun && outputsOff;
    endproperty
    a_permit_off: assert property (p_permit_off) // [RL1]
        else $error("run permit off did not stop");
    property p_remote_stop;
        ce && q.state == ST_RUN && runPermitInput && stopReq
            && !errStop |=> q.state == ST_DRAIN && engRun;
    endproperty
    a_remote_stop: assert property (p_remote_stop) // [RL7]
        else $error("stop request did not drain");
    property p_drain_end;
        ce && q.state == ST_DRAIN && runPermitInput && !errStop
            && scanEnd |=> q.state == ST_STOP && outputsOff;
    endproperty
    a_drain_end: assert property (p_drain_end) // [RL3]
        else $error("scan end did not stop");
    property p_drain_hold;
        ce && q.state == ST_DRAIN && runPermitInput && !errStop
            && !scanEnd |=> engRun;
    endproperty
    a_drain_hold: assert property (p_drain_hold) // [RL3]
        else $error("stopped before scan end");
    property p_restart;
        $rose(engRun) |-> s_restart;
    endproperty
    a_restart: assert property (p_restart) // [RL4]
        else $error("run without step zero restart");
    property p_all_withdraw;
        q.state == ST_STOP && stopReq |=> !engRun;
    endproperty
    a_all_withdraw: assert property (p_all_withdraw) // [RL8]
        else $error("run while a stop source holds");
    property p_outputs_off;
        !engRun |-> outputsOff;
    endproperty
    a_outputs_off: assert property (p_outputs_off) // [RL9]
        else $error("outputs not forced off in stop");
    property p_wd_fault;
        ce && runLike && ifc.expire |=> s_wd_fault
            and errorCodeWord == ERR_WDT;
    endproperty
    a_wd_fault: assert property (p_wd_fault) // [RL13]
        else $error("watchdog error not handled");
    property p_stop_class;
        ce && runLike && instrErr && instrErrStop |=> !engRun;
    endproperty
    a_stop_class: assert property (p_stop_class) // [RL15]
        else $error("stop class error did not halt");
    property p_bcd;
        ce && runLike && bcdErr && !instrErr && !ifc.expire
            && !q.ctrl[CTRL_OPERR_STOP]
            |=> diagErrorFlag && errorCodeWord == ERR_BCD
            && engSkip && runLed;
    endproperty
    a_bcd: assert property (p_bcd) // [RL19]
        else $error("BCD error not continued");
endmodule

/* File: dv/srss_engine_model.sv */
module srss_engine_model
    import srss_pkg::*;
(
    input wire logic sys_clk, // System clock
    input wire logic rst_n, // Async reset, low
    input wire logic engRun, // Engine executes
    output logic scanEnd // END processing done
);
    logic [4:0] stepCnt_q; // Steps of current scan
    // Fixed 30-cycle scan, restarted at step zero when stopped
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stepCnt_q <= 5'h00;
            scanEnd <= 1'b0;
        end
        else
        begin
            scanEnd <= engRun && stepCnt_q == 5'h1d;
            stepCnt_q <= (!engRun || stepCnt_q == 5'h1d) ? 5'h00
                : stepCnt_q + 5'h01;
        end
    end
endmodule

/* File: dv/srss_supervisor_bench.sv */
module srss_supervisor_bench
    import srss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b1, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, permit = 1'b1, scanEnd, bcdErr = 1'b0;
    logic opErr = 1'b0, instrErr = 1'b0, instrErrStop = 1'b0, led;
    logic [ECODE_W-1:0] code = '0;
    logic [INPUT_POINTS-1:0] inPoints = '0;
    logic engRun, engRestart, outputsOff, runLed, dFlag, sFlag, skip;
    logic [ECODE_W-1:0] errorCodeWord;
    int n_mismatch = 0, check_count = 0, cyc = 0;
    srss_supervisor #(.TICK_CYCLES(10)) uut (.sys_clk(sys_clk),
        .rst_n(rst_n), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .runPermitInput(permit), .inPoints(inPoints),
        .hwDiagOk(1'b1), .scanEnd(scanEnd), .instrErr(instrErr),
        .instrErrStop(instrErrStop), .instrErrCode(code), .opErr(opErr),
        .opErrCode(code), .bcdErr(bcdErr), .engRun(engRun),
        .engRestart(engRestart), .engSkip(skip), .outputsOff(outputsOff),
        .runLed(runLed), .diagErrorFlag(dFlag),
        .selfDiagErrorFlag(sFlag), .errorCodeWord(errorCodeWord));
    srss_engine_model eng (.sys_clk(sys_clk), .rst_n(rst_n),
        .engRun(engRun), .scanEnd(scanEnd));
    initial
    begin
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One single word transfer; read data taken at the data phase end edge
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        @(posedge sys_clk);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Bounded wait for the engine state, then compare it
    task automatic waitRun(input logic v);
        int i;
        i = 0;
        do @(posedge sys_clk); while (engRun !== v && ++i < 400);
        chk(engRun, v);
    endtask
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard, far above the planned run length
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        waitRun(1);
        chk(engRestart, 1'b1);
        bus(0, ADDR_WDSET, 0);
        chk(rd, 32'h14);
        bus(1, ADDR_PSEL, 32'h8f);
        bus(1, ADDR_CTRL, 32'h2);
        inPoints[143] <= 1'b1;
        // Status shows the state register, one cycle behind the request
        @(posedge sys_clk);
        bus(0, ADDR_STAT, 0);
        chk(rd[SB_DRAIN], 1'b1);
        waitRun(0);
        chk(outputsOff, 1'b1);
        bus(1, ADDR_CTRL, 32'h3);
        inPoints[143] <= 1'b0;
        repeat (20) @(posedge sys_clk);
        chk(engRun, 1'b0);
        bus(1, ADDR_CTRL, 32'h2);
        waitRun(1);
        chk(engRestart, 1'b1);
        permit <= 1'b0;
        waitRun(0);
        permit <= 1'b1;
        waitRun(1);
        @(posedge sys_clk) bcdErr <= 1'b1;
        @(posedge sys_clk) bcdErr <= 1'b0;
        bus(0, ADDR_ECODE, 0);
        chk(rd, 32'h32);
        chk({dFlag, engRun, hresp}, 3'h6);
        // Continue-class instruction fault skips and keeps running
        code <= 16'h1234;
        @(posedge sys_clk) instrErr <= 1'b1;
        @(posedge sys_clk) instrErr <= 1'b0;
        @(posedge sys_clk);
        chk({sFlag, engRun, skip, errorCodeWord}, {3'h7, code});
        // Stop-class fault halts; permit cycling leaves the fault
        instrErrStop <= 1'b1;
        @(posedge sys_clk) instrErr <= 1'b1;
        @(posedge sys_clk) instrErr <= 1'b0;
        waitRun(0);
        permit <= 1'b0;
        @(posedge sys_clk) permit <= 1'b1;
        waitRun(1);
        // Clear the self-diag flag so the watchdog must set it again
        bus(1, ADDR_STAT, 32'h20);
        bus(0, ADDR_STAT, 0);
        chk(rd[SB_SDIAG], 1'b0);
        bus(1, ADDR_WDSET, 32'h2);
        waitRun(0);
        chk({sFlag, outputsOff, errorCodeWord}, {2'h3, ERR_WDT});
        led = runLed;
        repeat (510) @(posedge sys_clk);
        chk(runLed, !led);
        print_verdict();
    end
endmodule
